// [hw/azfb_regs.sv]
// offset calibration and measurement feedback registers of the load channels
// How it works
// - bit 31 of a frame asks for a write when 1, and every answer has it 0.
// - a written 1 in bit 23 starts calibration of that channel while idle and its enable is off, 0 does not.
// - when calibration ends the 13-bit offset reads back in bits 12:0.
// - the feedback register never takes a write; such a frame is a read.
// - in calibration mode bits 23:8 give the 16-bit raw current.
// - mode 0, select 0: bits 23:12 give the last cycle's summed current.
// - summed current and peak current are cleared after every read.
// - mode 0, select 0: bits 11:0 give the last switching period.
// - all feedback fields read zero while the channel is not operating.
// - select 1: bits 23:16 give the peak, per dither cycle or since read.
// - select 1: bits 15:8 give the minimum, bits 7:0 periods per dither.
// - after each read the minimum is reloaded with all ones.
// - the period count reads zero without dither and clears on read.
`default_nettype none
module azfb_regs #(
  parameter int CHANNELS = 3
) (
  // clock, reset, enable
  input  wire logic                                 sys_clk,
  input  wire logic                                 rstn,
  input  wire logic                                 clkEn,
  // frame from the link controller and answer back
  input  wire logic                                 frameValid,
  input  wire azfb_pkg::azfb_frame_t                frame,
  output logic                                      respValid,
  output logic [31:0]                               respData,
  // mode settings and channel enables
  input  wire logic                                 calMode,
  input  wire logic                                 feedbackSelect,
  input  wire logic [CHANNELS-1:0]                  channelEnable,
  // offset calibration sequencer handshake
  output logic                                      calStart,
  output logic [1:0]                                calChannel,
  input  wire logic                                 calDone,
  input  wire logic [12:0]                          calOffset,
  // measurements of each channel
  input  wire azfb_pkg::azfb_meas_t [CHANNELS-1:0]  meas
);

  // channel field has two bits
  if (CHANNELS < 1 || CHANNELS > 3)
  begin : g_bad
    $error("CHANNELS must be 1 to 3");
  end

  // frame decode
  wire logic isOffset = frame.code == azfb_pkg::CODE_OFFSET_CAL;
  wire logic isFb     = frame.code == azfb_pkg::CODE_FEEDBACK;
  wire logic chanOk   = int'(frame.chan) < CHANNELS;
  wire logic offWrite = frameValid && isOffset && chanOk && frame.rw;
  wire logic fbRead   = frameValid && isFb && chanOk;

  // state
  azfb_pkg::azfb_cal_state_t calState_reg;
  logic [1:0]                calCh_reg;
  logic                      launch_reg;
  logic [12:0]               offset_reg [CHANNELS];
  logic [11:0]               accum_reg  [CHANNELS];
  logic [11:0]               period_reg [CHANNELS];
  logic [15:0]               raw_reg    [CHANNELS];
  logic [7:0]                trkMax_reg [CHANNELS];
  logic [7:0]                trkMin_reg [CHANNELS];
  logic [7:0]                trkCnt_reg [CHANNELS];
  logic [7:0]                repMax_reg [CHANNELS];
  logic [7:0]                repMin_reg [CHANNELS];
  logic [7:0]                repCnt_reg [CHANNELS];

  // launch only while idle and the channel enable is off
  wire logic launchOk = offWrite && frame.payload[azfb_pkg::LAUNCH_BIT]
                        && calState_reg == azfb_pkg::CAL_IDLE
                        && !channelEnable[frame.chan];

  // calibration sequencer
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      calState_reg <= azfb_pkg::CAL_IDLE;
      calCh_reg    <= azfb_pkg::CH_FIRST;
      calStart     <= 1'b0;
      launch_reg   <= azfb_pkg::LAUNCH_RESET;
    end
    else if (clkEn)
    begin
      calStart <= 1'b0;
      case (calState_reg)
        azfb_pkg::CAL_IDLE:
        begin
          if (launchOk)
          begin
            calState_reg <= azfb_pkg::CAL_BUSY;
            calCh_reg    <= frame.chan;
            calStart     <= 1'b1;
            launch_reg   <= 1'b1;
          end
        end
        azfb_pkg::CAL_BUSY:
        begin
          if (calDone)
            calState_reg <= azfb_pkg::CAL_IDLE;
        end
        default: calState_reg <= azfb_pkg::CAL_IDLE;
      endcase
    end
  end
  assign calChannel = calCh_reg;

  // per-channel offset and measurement capture
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_ch
    wire logic rd = fbRead && int'(frame.chan) == c;
    wire logic [7:0] smp = meas[c].sample;
    wire logic [7:0] newMax = (rd ? azfb_pkg::MAX_RELOAD : trkMax_reg[c]);
    wire logic [7:0] newMin = (rd ? azfb_pkg::MIN_RELOAD : trkMin_reg[c]);
    // a switch in the read cycle still counts after the clear
    wire logic [7:0] newCnt = (rd ? azfb_pkg::COUNT_RELOAD : trkCnt_reg[c]);

    // measured offset lands when the sequencer finishes
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
        offset_reg[c] <= azfb_pkg::OFFSET_RESET;
      else if (clkEn && calState_reg == azfb_pkg::CAL_BUSY && calDone
               && int'(calCh_reg) == c)
        offset_reg[c] <= calOffset;
    end

    // cycle results; a new cycle in the read cycle wins over the clear
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        accum_reg[c]  <= azfb_pkg::ACCUM_RELOAD;
        period_reg[c] <= 12'h000;
        raw_reg[c]    <= 16'h0000;
      end
      else if (clkEn)
      begin
        raw_reg[c] <= meas[c].rawCurrent;
        if (rd)
          accum_reg[c] <= azfb_pkg::ACCUM_RELOAD;
        if (meas[c].cycleDone)
        begin
          accum_reg[c]  <= meas[c].cycleCurrent;
          period_reg[c] <= meas[c].cyclePeriod;
        end
      end
    end

    // running peak, minimum and period count, restarted on read
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        trkMax_reg[c] <= azfb_pkg::MAX_RELOAD;
        trkMin_reg[c] <= azfb_pkg::MIN_RELOAD;
        trkCnt_reg[c] <= azfb_pkg::COUNT_RELOAD;
      end
      else if (clkEn)
      begin
        if (meas[c].ditherOn && meas[c].ditherEnd)
        begin
          trkMax_reg[c] <= azfb_pkg::MAX_RELOAD;
          trkMin_reg[c] <= azfb_pkg::MIN_RELOAD;
          trkCnt_reg[c] <= azfb_pkg::COUNT_RELOAD;
        end
        else
        begin
          trkMax_reg[c] <= newMax;
          trkMin_reg[c] <= newMin;
          if (meas[c].switchPulse)
            trkCnt_reg[c] <= newCnt + 8'h01;
          else
            trkCnt_reg[c] <= newCnt;
          if (meas[c].sampleValid && smp > newMax)
            trkMax_reg[c] <= smp;
          if (meas[c].sampleValid && smp < newMin)
            trkMin_reg[c] <= smp;
        end
      end
    end

    // dither cycle results, held until the next dither end or a read
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        repMax_reg[c] <= azfb_pkg::MAX_RELOAD;
        repMin_reg[c] <= azfb_pkg::MIN_RELOAD;
        repCnt_reg[c] <= azfb_pkg::COUNT_RELOAD;
      end
      else if (clkEn)
      begin
        if (rd)
        begin
          repMax_reg[c] <= azfb_pkg::MAX_RELOAD;
          repMin_reg[c] <= azfb_pkg::MIN_RELOAD;
          repCnt_reg[c] <= azfb_pkg::COUNT_RELOAD;
        end
        if (meas[c].ditherOn && meas[c].ditherEnd)
        begin
          repMax_reg[c] <= trkMax_reg[c];
          repMin_reg[c] <= trkMin_reg[c];
          repCnt_reg[c] <= trkCnt_reg[c];
        end
      end
    end
  end

  // field selection for the addressed channel
  wire logic [1:0] ch     = chanOk ? frame.chan : azfb_pkg::CH_FIRST;
  wire logic       dith   = meas[ch].ditherOn;
  wire logic       oper   = meas[ch].operating;
  wire logic [7:0] selMax = dith ? repMax_reg[ch] : trkMax_reg[ch];
  wire logic [7:0] selMin = dith ? repMin_reg[ch] : trkMin_reg[ch];
  wire logic [7:0] selCnt = dith ? repCnt_reg[ch] : 8'h00;
  wire logic [23:0] fbRaw = {raw_reg[ch], 8'h00};
  wire logic [23:0] fbSum = {accum_reg[ch], period_reg[ch]};
  wire logic [23:0] fbPk  = {selMax, selMin, selCnt};
  wire logic [23:0] fbSel = calMode ? fbRaw
                          : (feedbackSelect ? fbPk : fbSum);
  wire logic [23:0] fbOut = oper ? fbSel : 24'h000000;
  wire logic [23:0] azOut = {launch_reg, 10'h000, offset_reg[ch]};

  // answer word; direction bit always returns as 0
  wire logic [23:0] payOut = !chanOk ? 24'h000000
                           : isOffset ? azOut
                           : isFb ? fbOut
                           : 24'h000000;
  wire logic [31:0] respNext = {1'b0, frame.code, 1'b0, frame.chan,
                                payOut};

  // answer register, one cycle after each frame
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      respValid <= 1'b0;
      respData  <= 32'h00000000;
    end
    else if (clkEn)
    begin
      respValid <= frameValid;
      if (frameValid)
        respData <= respNext;
    end
  end

  // helper state for checks
  logic       fbIdle_q;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      fbIdle_q <= 1'b0;
    else if (clkEn)
      fbIdle_q <= fbRead && !oper;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_launch_req;
    clkEn && offWrite && frame.payload[azfb_pkg::LAUNCH_BIT]
      && calState_reg == azfb_pkg::CAL_IDLE;
  endsequence

  sequence s_fb_read;
    clkEn && fbRead;
  endsequence

  chk_resp_follows: assert property (clkEn && frameValid |=> respValid)
    else $error("no answer after a frame");
  chk_rw_zero: assert property (respValid |-> !respData[31])
    else $error("answer carries direction bit set");
  chk_launch_start: assert property
    (s_launch_req and (!channelEnable[frame.chan]) |=> calStart
      && calState_reg == azfb_pkg::CAL_BUSY)
    else $error("calibration did not start");
  chk_launch_blocked: assert property
    (s_launch_req and (channelEnable[frame.chan]) |=> !calStart)
    else $error("calibration started while channel enabled");
  chk_offset_store: assert property
    (clkEn && calState_reg == azfb_pkg::CAL_BUSY && calDone |=>
      offset_reg[calCh_reg] == $past(calOffset)
      && calState_reg == azfb_pkg::CAL_IDLE)
    else $error("offset not stored at calibration end");
  chk_fb_readonly: assert property
    (clkEn && fbRead && frame.rw |=> calState_reg == $past(calState_reg)
      && respData[30:27] == azfb_pkg::CODE_FEEDBACK)
    else $error("write frame changed feedback state");
  chk_accum_clear: assert property
    (s_fb_read and (!meas[frame.chan].cycleDone) |=>
      accum_reg[$past(frame.chan)] == azfb_pkg::ACCUM_RELOAD)
    else $error("summed current not cleared by read");
  chk_min_reload: assert property
    (s_fb_read and (!meas[frame.chan].sampleValid
      && !meas[frame.chan].ditherEnd) |=>
      trkMin_reg[$past(frame.chan)] == azfb_pkg::MIN_RELOAD)
    else $error("minimum not reloaded by read");
  chk_idle_zero: assert property (fbIdle_q |-> respData[23:0] == 24'h0)
    else $error("idle channel feedback not zero");
  chk_count_clear: assert property
    (s_fb_read and (!meas[frame.chan].ditherEnd
      && !meas[frame.chan].switchPulse) |=>
      trkCnt_reg[$past(frame.chan)] == azfb_pkg::COUNT_RELOAD)
    else $error("period count not cleared by read");

endmodule
`default_nettype wire

// [hw/azfb_pkg.sv]
// constants, frame layout and measurement carrier for the offset/feedback bank
`default_nettype none
package azfb_pkg;
  // frame field positions
  localparam int RW_BIT      = 31;
  localparam int CODE_HI     = 30;
  localparam int CODE_LO     = 27;
  localparam int CHAN_HI     = 25;
  localparam int CHAN_LO     = 24;
  localparam int LAUNCH_BIT  = 23;
  // register select codes in the frame
  localparam logic [3:0] CODE_OFFSET_CAL = 4'h7;
  localparam logic [3:0] CODE_FEEDBACK   = 4'h8;
  // values after reset
  localparam logic        LAUNCH_RESET = 1'h1;
  localparam logic [12:0] OFFSET_RESET = 13'h0000;
  localparam logic [7:0]  MIN_RELOAD   = 8'hFF;
  localparam logic [7:0]  MAX_RELOAD   = 8'h00;
  localparam logic [11:0] ACCUM_RELOAD = 12'h000;
  localparam logic [7:0]  COUNT_RELOAD = 8'h00;
  // one period count equals this many system clock cycles
  localparam int PERIOD_TICKS = 16;
  // channel codes
  localparam logic [1:0] CH_FIRST  = 2'h0;
  localparam logic [1:0] CH_SECOND = 2'h1;
  localparam logic [1:0] CH_THIRD  = 2'h2;

  // one register frame as it arrives from the link controller
  typedef struct packed {
    logic        rw;
    logic [3:0]  code;
    logic        spare;
    logic [1:0]  chan;
    logic [23:0] payload;
  } azfb_frame_t;

  // measurement results of one load channel from the regulation loop
  typedef struct packed {
    logic        operating;
    logic        ditherOn;
    logic        cycleDone;
    logic [11:0] cycleCurrent;
    logic [11:0] cyclePeriod;
    logic [15:0] rawCurrent;
    logic        sampleValid;
    logic [7:0]  sample;
    logic        switchPulse;
    logic        ditherEnd;
  } azfb_meas_t;

  typedef enum logic {CAL_IDLE, CAL_BUSY} azfb_cal_state_t;
endpackage
`default_nettype wire

// [tb/azfb_cal_model.sv]
// calibration sequencer stand-in that answers each start after a delay
`default_nettype none
module azfb_cal_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // start from the bank, delay and offset chosen by the bench
  input  wire logic        calStart,
  input  wire logic [15:0] delay,
  input  wire logic [12:0] offsetIn,
  // completion back to the bank
  output logic             calDone,
  output logic [12:0]      calOffset
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  // count down from a start; offset toggles when not qualified by done
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      cnt <= 0;
      calDone <= 1'b0;
      calOffset <= 13'h0000;
    end
    else
    begin
      calDone <= (cnt == 1);
      calOffset <= (cnt == 1) ? offsetIn : ~calOffset;
      cnt <= calStart ? int'(delay) : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule
`default_nettype wire

// [tb/test_azfb_regs.sv]
// self-checking bench for the offset and feedback register bank
`default_nettype none
module test_azfb_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       sys_clk = 1'b0;
  logic                       rstn = 1'b0;
  logic                       clkEn = 1'b1;
  logic                       frameValid = 1'b0;
  azfb_pkg::azfb_frame_t      frame = '0;
  logic                       respValid;
  logic [31:0]                respData;
  logic                       calMode = 1'b0;
  logic                       feedbackSelect = 1'b0;
  logic [2:0]                 channelEnable = 3'h0;
  logic                       calStart;
  logic [1:0]                 calChannel;
  logic                       calDone;
  logic [12:0]                calOffset;
  azfb_pkg::azfb_meas_t [2:0] meas = '0;
  logic [15:0]                calDelay = 16'h0001;
  logic [12:0]                offsetIn = 13'h0000;
  int                         fail_count = 0;
  int                         check_count = 0;
  integer                     seed = 32'hF83EB632;
  logic [31:0]                r;
  logic                       s;
  logic [15:0]                raw;
  logic [11:0]                cur;
  logic [11:0]                per;
  logic [7:0]                 a;
  logic [7:0]                 b;
  logic [7:0]                 mx;
  logic [7:0]                 mn;
  int                         n;
  int                         k;

  always #12.5 sys_clk = ~sys_clk;

  azfb_regs #(.CHANNELS(3)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .clkEn(clkEn), .frameValid(frameValid), .frame(frame),
    .respValid(respValid), .respData(respData), .calMode(calMode),
    .feedbackSelect(feedbackSelect), .channelEnable(channelEnable),
    .calStart(calStart), .calChannel(calChannel), .calDone(calDone),
    .calOffset(calOffset), .meas(meas));

  azfb_cal_model seq (.sys_clk(sys_clk), .rstn(rstn), .calStart(calStart),
    .delay(calDelay), .offsetIn(offsetIn), .calDone(calDone),
    .calOffset(calOffset));

  // expected answer words
  function automatic logic [31:0] ofs(int c, logic [12:0] v);
    return {1'b0, 4'h7, 1'b0, 2'(c), c < 3, 10'h000, v};
  endfunction
  function automatic logic [31:0] fb(int c, logic [23:0] f);
    return {1'b0, 4'h8, 1'b0, 2'(c), f};
  endfunction

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one frame from a rising edge; answer looked at half a cycle after the edge that takes the frame
  task automatic xfer(input logic w, input logic [3:0] c, input int ch,
                      input logic [23:0] p);
    frameValid <= 1'b1;
    frame <= {w, c, 1'b0, 2'(ch), p};
    @(posedge sys_clk);
    frameValid <= 1'b0;
    @(negedge sys_clk);
    check({31'h0, respValid}, 32'h1);
    r = respData;
    s = calStart;
    @(posedge sys_clk);
  endtask

  // pulses {cycleDone, ditherEnd, switchPulse, sampleValid} for one cycle
  task automatic pulse(input int ch, input logic [3:0] q, input logic [7:0] v);
    {meas[ch].cycleDone, meas[ch].ditherEnd} <= q[3:2];
    {meas[ch].switchPulse, meas[ch].sampleValid} <= q[1:0];
    meas[ch].sample <= v;
    @(posedge sys_clk);
    {meas[ch].cycleDone, meas[ch].ditherEnd} <= 2'h0;
    {meas[ch].switchPulse, meas[ch].sampleValid} <= 2'h0;
    meas[ch].sample <= ~v;
    @(posedge sys_clk);
  endtask

  // cut a hang short
  initial
  begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 4'h7, i, 24'h000000);
      check(r, ofs(i, 13'h0000));
    end
    // unknown register code: empty answer and no launch
    xfer(1'b1, 4'h5, 0, 24'h800000);
    check(r, 32'h28000000);
    check({31'h0, s}, 32'h0);
    // a frame offered while the clock enable is low is not taken
    clkEn <= 1'b0;
    frameValid <= 1'b1;
    frame <= {1'b0, 4'h8, 1'b0, 2'h0, 24'h000000};
    @(posedge sys_clk);
    frameValid <= 1'b0;
    clkEn <= 1'b1;
    @(negedge sys_clk);
    check({31'h0, respValid}, 32'h0);
    @(posedge sys_clk);
    $display("test reset values done");
    for (int i = 0; i < 3; i++)
    begin
      offsetIn <= 13'($random(seed));
      calDelay <= 16'(i * 12 + 1);
      channelEnable <= 3'(1 << i);
      xfer(1'b1, 4'h7, i, 24'h800000);
      check({31'h0, s}, 32'h0);
      channelEnable <= 3'h0;
      xfer(1'b1, 4'h7, i, 24'h000000);
      check({31'h0, s}, 32'h0);
      xfer(1'b1, 4'h7, i, 24'h800000);
      check({29'h0, calChannel, s}, {29'h0, 2'(i), 1'b1});
      if (i == 2)
      begin
        xfer(1'b1, 4'h7, 0, 24'h800000);
        check({31'h0, s}, 32'h0);
      end
      for (k = 0; k < 40 && calDone !== 1'b1; k++)
        @(negedge sys_clk);
      if (calDone !== 1'b1)
      begin
        fail_count++;
        tally_and_finish();
      end
      @(posedge sys_clk);
      @(posedge sys_clk);
      xfer(1'b0, 4'h7, i, 24'h000000);
      check(r, ofs(i, offsetIn));
    end
    $display("test calibration done");
    for (int i = 0; i < 3; i++)
    begin
      raw = 16'($random(seed));
      cur = 12'($random(seed));
      per = 12'($random(seed));
      calMode <= 1'b1;
      feedbackSelect <= 1'b0;
      meas[i].operating <= 1'b1;
      meas[i].ditherOn <= 1'b0;
      meas[i].rawCurrent <= raw;
      {meas[i].cycleCurrent, meas[i].cyclePeriod} <= {cur, per};
      @(posedge sys_clk);
      xfer(1'b0, 4'h8, i, 24'h000000);
      check(r, fb(i, {raw, 8'h00}));
      calMode <= 1'b0;
      pulse(i, 4'h8, 8'h00);
      xfer(1'b0, 4'h8, i, 24'h000000);
      check(r, fb(i, {cur, per}));
      xfer(1'b1, 4'h8, i, 24'hFFFFFF);
      check(r, fb(i, {12'h000, per}));
      feedbackSelect <= 1'b1;
      a = 8'($random(seed));
      b = 8'($random(seed));
      pulse(i, 4'h3, a);
      pulse(i, 4'h3, b);
      xfer(1'b0, 4'h8, i, 24'h000000);
      check(r, fb(i, {a > b ? a : b, a < b ? a : b, 8'h00}));
      xfer(1'b0, 4'h8, i, 24'h000000);
      check(r, fb(i, {8'h00, 8'hFF, 8'h00}));
      meas[i].ditherOn <= 1'b1;
      n = 1 + ($random(seed) & 7);
      mx = 8'h00;
      mn = 8'hFF;
      repeat (n)
      begin
        a = 8'($random(seed));
        mx = a > mx ? a : mx;
        mn = a < mn ? a : mn;
        pulse(i, 4'h3, a);
      end
      pulse(i, 4'h4, 8'h00);
      xfer(1'b0, 4'h8, i, 24'h000000);
      check(r, fb(i, {mx, mn, 8'(n)}));
      meas[i].operating <= 1'b0;
      @(posedge sys_clk);
      xfer(1'b0, 4'h8, i, 24'h000000);
      check(r, fb(i, 24'h000000));
    end
    $display("test feedback done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
